// ### design/rsh_homing.sv
// Homing sequencer for one stepper axis, with APB register access.
// Assumes switch and load inputs are asynchronous to pclk; step pulses
// are one pclk wide unless the rate is 0, and rate-divided by the speed registers.
//
// Operation
// RQ1: Homing runs as a state machine that opcode 13 starts, stops and reports.
// RQ2: End-switch auto-stop settings have no effect while homing runs.
// RQ3: Until the switch is first seen the motor steps at the search speed.
// RQ4: After the hit it creeps off the switch, re-enters from the other side and zeroes at the midpoint.
// RQ5: The release and re-enter phase steps at the calibration speed.
// RQ6: The mode comes from the mode register; mode 1 homes on the left end switch.
// RQ7: Mode 4 reaches the left end switch from both sides and zeroes at its middle.
// RQ8: Mode 5 seeks home going negative and reverses on the left end switch.
// RQ9: Mode 6 seeks home going positive and reverses on the right end switch.
// RQ10: Mode 7 seeks home going negative, ignores end switches, zeroes at its middle.
// RQ11: Mode 8 seeks home going positive, ignores end switches, zeroes at its middle.
// RQ12: Adding 64 to mode 1 or 4 uses the right end switch instead of the left.
// RQ13: Adding 128 to modes 5 to 8 inverts the home switch polarity.
// RQ14: With stall detection on, a load reading at or below threshold halts the motor.
// RQ15: The load reading falls linearly with load and is zero at full load.
// RQ16: Done is reported only after zero is written, and stop halts a search.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
module rsh_homing
  import rsh_pkg::*;
#(
  parameter int SPW = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire rsh_sw_s     sw_in,
  input  wire logic [9:0]  load_in,
  input  wire logic [15:0] speed_now,
  output rsh_mot_s         mot,
  output logic             busy,
  output logic             irq
);

  rsh_sw_s     sw_s1_reg, sw_s2_reg;
  logic [9:0]  ld_s1_reg, ld_s2_reg;
  logic [7:0]  mode_reg;
  logic [SPW-1:0] sspeed_reg, cspeed_reg;
  logic [9:0]  stall_thr_reg;
  logic        stall_en_reg;
  logic [15:0] vmin_reg;
  logic [31:0] pos_reg, zero_reg, edge_a_reg;
  logic [SPW-1:0] div_reg;
  logic [RSH_IRQ_W-1:0] irq_st_reg, irq_msk_reg;
  logic        start_p, stop_p, st_rd;
  rsh_state_e  state_reg;
  logic        dir_reg, fail_reg;
  logic        moving, tick, sw_hit, rev_hit, stall_hit, use_right;
  logic [7:0]  base_mode;
  logic [SPW-1:0] rate;
  logic        apb_acc;

  // Two-stage capture of asynchronous inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_s1_reg <= '0;
      sw_s2_reg <= '0;
      ld_s1_reg <= '0;
      ld_s2_reg <= '0;
    end else begin
      sw_s1_reg <= sw_in;
      sw_s2_reg <= sw_s1_reg;
      ld_s1_reg <= load_in;
      ld_s2_reg <= ld_s1_reg;
    end
  end

  assign apb_acc = psel && penable;
  assign start_p = apb_acc && pwrite && paddr == RSH_A_CMD &&
                   pwdata[7:0] == RSH_OPCODE &&
                   pwdata[9:8] == RSH_ACT_START; // RQ1
  assign stop_p  = apb_acc && pwrite && paddr == RSH_A_CMD &&
                   pwdata[7:0] == RSH_OPCODE &&
                   pwdata[9:8] == RSH_ACT_STOP; // RQ1
  assign st_rd   = apb_acc && !pwrite && paddr == RSH_A_IRQST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg      <= RSH_M_LEFT;
      sspeed_reg    <= SPW'(RSH_SSPEED_RST);
      cspeed_reg    <= SPW'(RSH_CSPEED_RST);
      stall_thr_reg <= RSH_STALL_RST;
      stall_en_reg  <= 1'b0;
      vmin_reg      <= RSH_VMIN_RST;
      irq_msk_reg   <= '0;
    end else if (apb_acc && pwrite) begin
      case (paddr)
        RSH_A_MODE:   mode_reg <= pwdata[7:0]; // RQ6
        RSH_A_SSPEED: sspeed_reg <= pwdata[SPW-1:0];
        RSH_A_CSPEED: cspeed_reg <= pwdata[SPW-1:0];
        RSH_A_STALL: begin
          stall_thr_reg <= pwdata[9:0];
          stall_en_reg  <= pwdata[31];
          vmin_reg      <= pwdata[30:15];
        end
        RSH_A_IRQMSK: irq_msk_reg <= pwdata[RSH_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Zero-wait slave; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        case (paddr)
          RSH_A_CMD:    prdata <= {29'h0, fail_reg, busy,
                                   state_reg == RSH_DONE}; // RQ1
          RSH_A_MODE:   prdata <= {24'h0, mode_reg};
          RSH_A_SSPEED: prdata <= 32'(sspeed_reg);
          RSH_A_CSPEED: prdata <= 32'(cspeed_reg);
          RSH_A_STALL:  prdata <= {stall_en_reg, vmin_reg, 5'h0,
                                   stall_thr_reg};
          RSH_A_STATUS: prdata <= {29'h0, sw_s2_reg};
          RSH_A_POS:    prdata <= pos_reg;
          RSH_A_ZERO:   prdata <= zero_reg;
          RSH_A_LOAD:   prdata <= {22'h0, ld_s2_reg}; // RQ15
          RSH_A_IRQST:  prdata <= 32'(irq_st_reg);
          RSH_A_IRQMSK: prdata <= 32'(irq_msk_reg);
          default:      pslverr <= 1'b1;
        endcase
      end
    end
  end

  assign use_right = mode_reg[RSH_BIT_RIGHT]; // RQ12
  assign base_mode = mode_reg & 8'h3f & ~(8'h1 << RSH_BIT_INV);
  // Home polarity is flipped only in the home-switch modes
  always_comb begin
    sw_hit  = 1'b0;
    rev_hit = 1'b0;
    case (base_mode)
      RSH_M_LEFT, RSH_M_LEFT2:
        sw_hit = use_right ? sw_s2_reg.right : sw_s2_reg.left; // RQ6 RQ12
      RSH_M_HNEG: begin
        sw_hit  = sw_s2_reg.home ^ mode_reg[RSH_BIT_INV]; // RQ13
        rev_hit = sw_s2_reg.left; // RQ8
      end
      RSH_M_HPOS: begin
        sw_hit  = sw_s2_reg.home ^ mode_reg[RSH_BIT_INV]; // RQ13
        rev_hit = sw_s2_reg.right; // RQ9
      end
      RSH_M_HNEG_FR, RSH_M_HPOS_FR:
        sw_hit = sw_s2_reg.home ^ mode_reg[RSH_BIT_INV]; // RQ10 RQ11
      default: ;
    endcase
  end

  // Stall counts only above the minimum speed
  assign stall_hit = stall_en_reg && speed_now > vmin_reg &&
                     ld_s2_reg <= stall_thr_reg; // RQ14 RQ15

  assign moving = state_reg inside {RSH_SEEK, RSH_LEAVE, RSH_BACK,
                                    RSH_REENTER};
  assign rate   = state_reg == RSH_SEEK ? sspeed_reg : cspeed_reg; // RQ3 RQ5
  assign tick   = moving && div_reg == '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (!moving || div_reg == '0) begin
      div_reg <= rate;
    end else begin
      div_reg <= div_reg - SPW'(1);
    end
  end

  // End-switch auto-stop is not consulted here at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= RSH_IDLE;
      dir_reg    <= 1'b0;
      fail_reg   <= 1'b0;
      edge_a_reg <= '0;
      zero_reg   <= '0;
    end else if (stop_p || (moving && stall_hit)) begin
      state_reg <= RSH_IDLE; // RQ14 RQ16
      fail_reg  <= 1'b1;
    end else begin
      case (state_reg)
        RSH_IDLE, RSH_DONE: if (start_p) begin // RQ1 RQ2
          state_reg <= RSH_SEEK;
          fail_reg  <= 1'b0;
          dir_reg   <= base_mode == RSH_M_HPOS ||
                       base_mode == RSH_M_HPOS_FR ||
                       (base_mode inside {RSH_M_LEFT, RSH_M_LEFT2}
                        && use_right); // RQ9 RQ11 RQ12
        end
        RSH_SEEK: begin
          if (sw_hit) begin
            state_reg  <= RSH_LEAVE; // RQ3 RQ4
            edge_a_reg <= pos_reg;
          end else if (rev_hit) begin
            // Point away from the end switch; a toggle would chatter
            dir_reg <= base_mode == RSH_M_HNEG; // RQ8 RQ9
          end
        end
        RSH_LEAVE: if (!sw_hit) begin // RQ4
          state_reg <= RSH_BACK;
          dir_reg   <= ~dir_reg;
        end
        RSH_BACK: if (sw_hit) begin
          // Crossing back in: keep going to far edge
          state_reg  <= RSH_REENTER; // RQ7
          edge_a_reg <= pos_reg;
        end
        RSH_REENTER: if (!sw_hit) begin // RQ4 RQ7 RQ10 RQ11
          state_reg <= RSH_SETZERO;
        end
        RSH_SETZERO: begin
          zero_reg  <= 32'(($signed(edge_a_reg) + $signed(pos_reg)) >>> 1);
          state_reg <= RSH_DONE; // RQ16
        end
        default: state_reg <= RSH_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg  <= '0;
    end else begin
      if (tick) begin // RQ3 RQ5
        pos_reg <= dir_reg ? pos_reg + 32'h1 : pos_reg - 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      mot  <= '0;
    end else begin
      busy <= moving || state_reg == RSH_SETZERO;
      mot  <= '{step: tick, dir: dir_reg};
    end
  end

  // Set wins over read-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg <= '0;
      irq        <= 1'b0;
    end else begin
      irq_st_reg <= (st_rd ? '0 : irq_st_reg) |
                    {RSH_IRQ_W{1'b0}} |
                    (RSH_IRQ_W'(state_reg == RSH_SETZERO) << RSH_IRQ_DONE) |
                    (RSH_IRQ_W'(moving && stall_hit) << RSH_IRQ_STALL) |
                    (RSH_IRQ_W'(stop_p) << RSH_IRQ_STOP);
      irq <= |(irq_st_reg & irq_msk_reg);
    end
  end

  chk_done_after_zero: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == RSH_SETZERO |=> state_reg == RSH_DONE ||
    $past(stop_p)) else $error("done not after zero"); // RQ16
  chk_stop_halts: assert property (@(posedge pclk) disable iff (!presetn)
    stop_p |=> state_reg == RSH_IDLE ##1 !busy)
    else $error("stop did not halt"); // RQ16
  chk_start_seek: assert property (@(posedge pclk) disable iff (!presetn)
    start_p && state_reg == RSH_IDLE && !stall_hit |=> state_reg == RSH_SEEK)
    else $error("start ignored"); // RQ1
  chk_stall_stop: assert property (@(posedge pclk) disable iff (!presetn)
    moving && stall_hit && !stop_p |=> state_reg == RSH_IDLE && fail_reg)
    else $error("stall not stopped"); // RQ14
  chk_seek_rate: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == RSH_SEEK |-> rate == sspeed_reg)
    else $error("wrong search speed"); // RQ3
  chk_cal_rate: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg inside {RSH_LEAVE, RSH_BACK, RSH_REENTER} |-> rate == cspeed_reg)
    else $error("wrong calibration speed"); // RQ5
  chk_seek_hit: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == RSH_SEEK && sw_hit && !stop_p && !stall_hit
    |=> state_reg == RSH_LEAVE) else $error("hit missed"); // RQ4
  chk_mode5_rev: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == RSH_SEEK && base_mode == RSH_M_HNEG && rev_hit && !sw_hit
    && !stop_p && !stall_hit |=> dir_reg)
    else $error("no reversal"); // RQ8
  chk_step_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    mot.step |=> !mot.step || rate == '0) else $error("step too long"); // RQ3

endmodule : rsh_homing

// ### design/rsh_pkg.sv
// Package for the homing block: register map, mode codes, field layouts.
// Assumes an APB slave with 32-bit data and one word per register.
package rsh_pkg;

  localparam logic [7:0] RSH_A_CMD     = 8'h00;
  localparam logic [7:0] RSH_A_MODE    = 8'h04;
  localparam logic [7:0] RSH_A_SSPEED  = 8'h08;
  localparam logic [7:0] RSH_A_CSPEED  = 8'h0c;
  localparam logic [7:0] RSH_A_STALL   = 8'h10;
  localparam logic [7:0] RSH_A_STATUS  = 8'h14;
  localparam logic [7:0] RSH_A_POS     = 8'h18;
  localparam logic [7:0] RSH_A_ZERO    = 8'h1c;
  localparam logic [7:0] RSH_A_LOAD    = 8'h20;
  localparam logic [7:0] RSH_A_IRQST   = 8'h24;
  localparam logic [7:0] RSH_A_IRQMSK  = 8'h28;

  // Command word: opcode in low byte, action in next byte
  localparam logic [7:0] RSH_OPCODE    = 8'h0d;
  localparam logic [1:0] RSH_ACT_START = 2'h0;
  localparam logic [1:0] RSH_ACT_STOP  = 2'h1;

  localparam logic [7:0] RSH_M_LEFT     = 8'h01;
  localparam logic [7:0] RSH_M_LEFT2    = 8'h04;
  localparam logic [7:0] RSH_M_HNEG     = 8'h05;
  localparam logic [7:0] RSH_M_HPOS     = 8'h06;
  localparam logic [7:0] RSH_M_HNEG_FR  = 8'h07;
  localparam logic [7:0] RSH_M_HPOS_FR  = 8'h08;
  localparam int         RSH_BIT_RIGHT  = 6;
  localparam int         RSH_BIT_INV    = 7;

  localparam logic [15:0] RSH_SSPEED_RST = 16'h0100;
  localparam logic [15:0] RSH_CSPEED_RST = 16'h0010;
  localparam logic [9:0]  RSH_STALL_RST  = 10'h000;
  localparam logic [15:0] RSH_VMIN_RST   = 16'h0000;

  // Interrupt status bits
  localparam int RSH_IRQ_DONE  = 0;
  localparam int RSH_IRQ_STALL = 1;
  localparam int RSH_IRQ_STOP  = 2;
  localparam int RSH_IRQ_W     = 3;

  typedef struct packed {
    logic home;
    logic left;
    logic right;
  } rsh_sw_s;

  typedef struct packed {
    logic        step;
    logic        dir;
  } rsh_mot_s;

  typedef enum logic [2:0] {
    RSH_IDLE, RSH_SEEK, RSH_LEAVE, RSH_BACK, RSH_REENTER, RSH_SETZERO,
    RSH_DONE
  } rsh_state_e;

endpackage : rsh_pkg

// ### sim/rsh_stage.sv
// Stage model: a ring of 80 steps with left, right and home switch bands.
// Assumes mot is registered and step is a one-cycle pulse.
`timescale 1ns/100ps
module rsh_stage
  import rsh_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire rsh_mot_s mot,
  input  wire logic     inv_home,
  output rsh_sw_s       sw
);
  int pos;
  // Ring lets the end-switch-blind modes wrap round to home
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pos <= 0;
    else if (mot.step)
      pos <= mot.dir ? (pos == 39 ? -40 : pos + 1)
                     : (pos == -40 ? 39 : pos - 1);
  end
  assign sw.home  = inv_home ^ (pos >= 6 && pos <= 10);
  assign sw.left  = pos >= -30 && pos <= -20;
  assign sw.right = pos >= 20 && pos <= 30;
endmodule : rsh_stage

// ### sim/tb.sv
// Self-checking bench for the homing block, driven over APB.
// Assumes the stage model above; all modes run from a fresh reset.
`timescale 1ns/100ps
module tb;
  import rsh_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        inv_home = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [9:0]  load_in = 10'h3ff;
  logic [15:0] speed_now = 16'h0100;
  logic [31:0] prdata, q;
  logic        pready, pslverr, busy, irq, perr;
  logic [9:0]  thr;
  rsh_sw_s     sw_in;
  rsh_mot_s    mot;
  int          err_total, num_checks, cnt, ss, cs, n0;
  int          gaps[$];
  logic [7:0]  md[12] = '{8'h01, 8'h04, 8'h41, 8'h44, 8'h05, 8'h06,
                          8'h07, 8'h08, 8'h85, 8'h86, 8'h87, 8'h88};
  int          lo[12] = '{-32, -32, 18, 18, 4, 4, -76, 4, 4, 4, -76, 4};
  int          hi[12] = '{-18, -18, 32, 32, 12, 12, -68, 12, 12, 12, -68, 12};

  rsh_homing #(.SPW(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sw_in(sw_in),
    .load_in(load_in), .speed_now(speed_now), .mot(mot), .busy(busy),
    .irq(irq));
  rsh_stage stage (.pclk(pclk), .presetn(presetn), .mot(mot),
    .inv_home(inv_home), .sw(sw_in));

  initial begin
    forever #50 pclk = ~pclk;
  end

  // Step spacing, in cycles
  always @(posedge pclk) begin
    if (mot.step === 1'b1) begin
      gaps.push_back(cnt);
      cnt = 1;
    end else
      cnt++;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  // Divider reloads with the rate, so steps are rate + 1 cycles apart
  function automatic logic [31:0] exp_gap(int s);
    return 32'(s + 1);
  endfunction : exp_gap

  function automatic logic [31:0] exp_zero(logic [31:0] z, int l, int h);
    return ($signed(z) >= l && $signed(z) <= h) ? z : 32'(l);
  endfunction : exp_zero

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64)
      err_total++;
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  task automatic run(input logic [1:0] act);
    int n;
    n = 0;
    gaps.delete();
    apb(1'b1, RSH_A_CMD, {22'h0, act, RSH_OPCODE});
    repeat (2) @(posedge pclk);
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    // Status and irq have settled by the edge on which busy falls
    repeat (2) @(posedge pclk);
  endtask : run

  initial begin
    void'($urandom(22972));
    do_reset();
    rd(RSH_A_MODE, 32'h1);
    rd(RSH_A_SSPEED, 32'h100);
    rd(RSH_A_CSPEED, 32'h10);
    rd(8'h3c, 32'h0);
    chk({31'h0, perr}, 32'h1);
    $display("registers done");
    for (int i = 0; i < 12; i++) begin
      inv_home <= md[i][RSH_BIT_INV];
      do_reset();
      ss = 4 + $urandom % 4;
      cs = 8 + $urandom % 4;
      apb(1'b1, RSH_A_MODE, {24'h0, md[i]});
      apb(1'b1, RSH_A_SSPEED, 32'(ss));
      apb(1'b1, RSH_A_CSPEED, 32'(cs));
      apb(1'b1, RSH_A_IRQMSK, 32'h7);
      run(RSH_ACT_START);
      chk({31'h0, irq}, 32'h1);
      rd(RSH_A_CMD, 32'h1);
      apb(1'b0, RSH_A_ZERO, 32'h0);
      chk(q, exp_zero(q, lo[i], hi[i]));
      chk(32'(gaps.size() > 2), 32'h1);
      chk(32'(gaps[1]), exp_gap(ss));
      chk(32'(gaps[$]), exp_gap(cs));
      rd(RSH_A_IRQST, 32'h1);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      $display("mode %h done", md[i]);
    end
    do_reset();
    apb(1'b1, RSH_A_MODE, 32'h7);
    apb(1'b1, RSH_A_IRQMSK, 32'h7);
    gaps.delete();
    apb(1'b1, RSH_A_CMD, {22'h0, RSH_ACT_START, RSH_OPCODE});
    repeat (300) @(posedge pclk);
    run(RSH_ACT_STOP);
    n0 = gaps.size();
    repeat (50) @(posedge pclk);
    chk(32'(gaps.size()), 32'(n0));
    rd(RSH_A_CMD, 32'h4);
    rd(RSH_A_IRQST, 32'h4);
    $display("stop done");
    do_reset();
    thr = 10'(100 + $urandom % 400);
    load_in <= thr - 10'($urandom % 50);
    apb(1'b1, RSH_A_STALL, {1'b1, 16'h0, 5'h0, thr});
    apb(1'b1, RSH_A_IRQMSK, 32'h0);
    run(RSH_ACT_START);
    chk({31'h0, busy}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(RSH_A_CMD, 32'h4);
    rd(RSH_A_LOAD, {22'h0, load_in});
    rd(RSH_A_IRQST, 32'h2);
    $display("stall done");
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    end_of_test();
  end
endmodule : tb
